/* core/aesf_pkg.sv */
// constants for the accelerometer status and event flag block
// assumes a single 125 MHz core clock and an on-chip register access port
package aesf_pkg;
   // register offsets and reset values
   localparam logic [7:0] AESF_OFS_MODE_STATUS = 8'h08;
   localparam logic [7:0] AESF_OFS_EVENT_FLAGS = 8'h09;
   localparam logic [7:0] AESF_RST_MODE_STATUS = 8'h10;
   localparam logic [7:0] AESF_RST_EVENT_FLAGS = 8'h00;
   // mode and fifo status fields
   localparam int AESF_BIT_NEW_SAMPLE = 3;
   localparam int AESF_BIT_QUEUE_EMPTY = 4;
   localparam int AESF_BIT_QUEUE_FULL = 5;
   localparam int AESF_BIT_LEVEL_REACHED = 6;
   localparam int AESF_BIT_PENDING = 7;
   // event flag fields
   localparam int AESF_EVT_AUTO_WAKE = 2;
   localparam int AESF_EVT_ACQ = 3;
   localparam int AESF_EVT_EMPTY = 4;
   localparam int AESF_EVT_FULL = 5;
   localparam int AESF_EVT_LEVEL = 6;
   localparam int AESF_EVT_COMBINED = 7;
   // mode readback codes
   localparam logic [2:0] AESF_MODE_SLEEP = 3'h0;
   localparam logic [2:0] AESF_MODE_STANDBY = 3'h1;
   localparam logic [2:0] AESF_MODE_WATCH = 3'h2;
   localparam logic [2:0] AESF_MODE_RSV_A = 3'h3;
   localparam logic [2:0] AESF_MODE_RSV_B = 3'h4;
   localparam logic [2:0] AESF_MODE_CONT = 3'h5;
   localparam logic [2:0] AESF_MODE_COMBINED = 3'h6;
   localparam logic [2:0] AESF_MODE_BURST = 3'h7;
   // sizes and timing
   localparam int AESF_QUEUE_DEPTH = 32;
   localparam logic [7:0] AESF_BURST_ENDLESS = 8'h00;
   localparam logic [1:0] AESF_MODE_SETTLE_BEATS = 2'h3;
   localparam int AESF_CLK_PERIOD_PS = 8000;
   localparam int AESF_HB_PERIOD_NS = 1000;
   localparam int AESF_HB_CYCLES = (AESF_HB_PERIOD_NS * 1000) / AESF_CLK_PERIOD_PS;
   typedef enum logic [0:0] {AESF_MS_IDLE, AESF_MS_WAIT} aesf_cmd_state_t;
endpackage

/* core/aesf_flag_cell.sv */
// one sticky event flag with optional re-arm on condition release
// assumes condition, enable and clear are on the core clock
`timescale 1ns/1ps
`default_nettype none
module aesf_flag_cell #(
   parameter bit REARM_ON_LOW = 1'b0
) (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   // event
   input  wire logic enable_in,
   input  wire logic cond_in,
   input  wire logic clear_in,
   // state
   output logic      flag_out,
   output logic      set_out
);
   logic flag_ff;
   logic armed_ff;
   logic nxt_flag;
   logic nxt_armed;
   logic set_now;

   always_comb begin
      set_now = enable_in & cond_in & armed_ff;
      nxt_flag = set_now | (flag_ff & ~clear_in);          // set wins over clear
      nxt_armed = armed_ff;
      if (!REARM_ON_LOW) begin
         nxt_armed = 1'b1;
      end else if (set_now) begin
         nxt_armed = 1'b0;
      end else if (!cond_in) begin
         nxt_armed = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flag_ff <= 1'b0;
         armed_ff <= 1'b1;
      end else begin
         flag_ff <= nxt_flag;
         armed_ff <= nxt_armed;
      end
   end

   assign flag_out = flag_ff;
   assign set_out = set_now;
endmodule
`default_nettype wire

/* core/aesf_status_flags.sv */
// mode readback, fifo level status and sticky event flags
// assumes the host access port, fifo and detector all run on ref_clk_in
//
// What this block does
// - Reported mode follows a command after at most three heartbeat transitions.
// - Mode 000 is sleep, 001 standby; 011 and 100 are reserved.
// - Mode 010 watches activity and moves itself to continuous mode on detection.
// - Mode 101 samples three axes continuously with the activity watch off.
// - Mode 110 runs detector, sampling pipeline and fifo together.
// - Mode 111 takes 1 to 255 samples or endless, then returns to sleep.
// - New-sample bit 3 sets on every fresh sample, regardless of enables.
// - Fifo-empty bit 4 is a level, reading 1 straight after reset.
// - Level-reached bit 6 is 1 while fifo count is at or above threshold.
// - Pending bit 7 is 1 whenever any event flag is set.
// - An event flag sets only when its interrupt enable bit is 1.
// - Clear by reading flags on I2C, or by writing when selected or on SPI.
// - Auto-wake flag bit 2 sets on each watch to continuous move.
// - Acquisition flag bit 3 sets per sample in continuous and triggered modes.
// - Fifo-empty flag bit 4 re-triggers only after non-empty then empty again.
// - Fifo-full flag bit 5 sets at 32 samples, re-triggers after leaving full.
// - Level flag bit 6 sets when count reaches the 5-bit threshold.
// - Combined flag bit 7 sets on detection in mode 110; detector then holds.
// - An option resets the detector when the combined flag is cleared.
// - Option 1 re-arms on clear; option 0 re-arms only on leaving mode 110.
// - Capture-halt option stops fifo capture once the combined flag sets.
`timescale 1ns/1ps
`default_nettype none
module aesf_status_flags #(
   parameter int HB_CYCLES = aesf_pkg::AESF_HB_CYCLES,
   parameter int QUEUE_DEPTH = aesf_pkg::AESF_QUEUE_DEPTH
) (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // register access port
   input  wire logic       reg_rd_stb_in,
   input  wire logic       reg_wr_stb_in,
   input  wire logic [7:0] reg_addr_in,
   output logic      [7:0] reg_rdata_out,
   // configuration from other registers
   input  wire logic       spi_mode_in,
   input  wire logic       clear_by_write_in,
   input  wire logic       detector_rearm_on_clear_in,
   input  wire logic       capture_halt_in,
   input  wire logic [7:0] int_enable_in,
   input  wire logic [4:0] level_threshold_in,
   input  wire logic [7:0] burst_samples_in,
   // mode command
   input  wire logic       mode_cmd_wr_in,
   input  wire logic [2:0] mode_cmd_in,
   // datapath events
   input  wire logic       sample_written_in,
   input  wire logic [5:0] queue_count_in,
   input  wire logic       activity_detect_in,
   // state outputs
   output logic      [2:0] mode_out,
   output logic            detector_active_out,
   output logic            sampling_active_out,
   output logic            detector_armed_out,
   output logic            capture_halt_out,
   output logic            any_flag_pending_out
);
   import aesf_pkg::*;

   localparam int HBW = $clog2(HB_CYCLES + 1);
   localparam logic [5:0] QDEPTH = 6'(QUEUE_DEPTH);

   // heartbeat divider
   logic [HBW-1:0] hb_cnt_ff;
   logic [HBW-1:0] nxt_hb_cnt;
   logic           hb_tick;

   always_comb begin
      hb_tick = (hb_cnt_ff == HBW'(HB_CYCLES - 1));
      nxt_hb_cnt = hb_tick ? '0 : hb_cnt_ff + HBW'(1);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hb_cnt_ff <= '0;
      end else begin
         hb_cnt_ff <= nxt_hb_cnt;
      end
   end

   // access decode
   logic rd_mode;
   logic rd_flags;
   logic wr_flags;
   logic clear_evt;

   always_comb begin
      rd_mode = reg_rd_stb_in && (reg_addr_in == AESF_OFS_MODE_STATUS);
      rd_flags = reg_rd_stb_in && (reg_addr_in == AESF_OFS_EVENT_FLAGS);
      wr_flags = reg_wr_stb_in && (reg_addr_in == AESF_OFS_EVENT_FLAGS);
      clear_evt = (rd_flags && !spi_mode_in && !clear_by_write_in)
                  || (wr_flags && (spi_mode_in || clear_by_write_in));
   end

   // mode command settling and mode state
   aesf_cmd_state_t cmd_state_ff;
   aesf_cmd_state_t nxt_cmd_state;
   logic [2:0]      cmd_ff;
   logic [2:0]      nxt_cmd;
   logic [1:0]      beats_ff;
   logic [1:0]      nxt_beats;
   logic [2:0]      mode_ff;
   logic [2:0]      nxt_mode;
   logic [7:0]      burst_cnt_ff;
   logic [7:0]      nxt_burst_cnt;
   logic            cmd_legal;
   logic            cmd_apply;
   logic            auto_wake;
   logic            burst_done;
   logic            det_armed_ff;

   always_comb begin
      cmd_legal = (mode_cmd_in != AESF_MODE_RSV_A) && (mode_cmd_in != AESF_MODE_RSV_B);
      nxt_cmd_state = cmd_state_ff;
      nxt_cmd = cmd_ff;
      nxt_beats = beats_ff;
      cmd_apply = 1'b0;
      case (cmd_state_ff)
         AESF_MS_IDLE: begin
            if (mode_cmd_wr_in && cmd_legal) begin
               nxt_cmd = mode_cmd_in;
               nxt_beats = 2'h0;
               nxt_cmd_state = AESF_MS_WAIT;
            end
         end
         AESF_MS_WAIT: begin
            if (mode_cmd_wr_in && cmd_legal) begin
               nxt_cmd = mode_cmd_in;                          // newer command restarts the wait
               nxt_beats = 2'h0;
            end else if (hb_tick) begin
               nxt_beats = beats_ff + 2'h1;
               if (beats_ff == AESF_MODE_SETTLE_BEATS - 2'h1) begin
                  cmd_apply = 1'b1;
                  nxt_cmd_state = AESF_MS_IDLE;
               end
            end
         end
         default: nxt_cmd_state = AESF_MS_IDLE;
      endcase
      auto_wake = (mode_ff == AESF_MODE_WATCH) && activity_detect_in;
      burst_done = (mode_ff == AESF_MODE_BURST) && sample_written_in
                   && (burst_samples_in != AESF_BURST_ENDLESS)
                   && (burst_cnt_ff + 8'h01 >= burst_samples_in);
      nxt_mode = mode_ff;
      if (cmd_apply) begin
         nxt_mode = cmd_ff;
      end else if (auto_wake) begin
         nxt_mode = AESF_MODE_CONT;
      end else if (burst_done) begin
         nxt_mode = AESF_MODE_SLEEP;
      end
      nxt_burst_cnt = burst_cnt_ff;
      if (mode_ff != AESF_MODE_BURST || cmd_apply) begin
         nxt_burst_cnt = 8'h00;
      end else if (sample_written_in) begin
         nxt_burst_cnt = burst_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_state_ff <= AESF_MS_IDLE;
         cmd_ff <= AESF_MODE_SLEEP;
         beats_ff <= 2'h0;
         mode_ff <= AESF_MODE_SLEEP;
         burst_cnt_ff <= 8'h00;
      end else begin
         cmd_state_ff <= nxt_cmd_state;
         cmd_ff <= nxt_cmd;
         beats_ff <= nxt_beats;
         mode_ff <= nxt_mode;
         burst_cnt_ff <= nxt_burst_cnt;
      end
   end

   // event flags
   logic [7:0] flag_vec;
   logic [7:0] set_vec;
   logic [7:0] cond_vec;
   logic       q_empty;
   logic       q_full;
   logic       q_level;

   always_comb begin
      q_empty = (queue_count_in == 6'h00);
      q_full = (queue_count_in >= QDEPTH);
      q_level = (queue_count_in >= {1'b0, level_threshold_in});
      cond_vec = 8'h00;
      cond_vec[AESF_EVT_AUTO_WAKE] = auto_wake && !cmd_apply;
      cond_vec[AESF_EVT_ACQ] = sample_written_in
         && (mode_ff == AESF_MODE_CONT || mode_ff == AESF_MODE_BURST);
      cond_vec[AESF_EVT_EMPTY] = q_empty;
      cond_vec[AESF_EVT_FULL] = q_full;
      cond_vec[AESF_EVT_LEVEL] = q_level;
      cond_vec[AESF_EVT_COMBINED] = activity_detect_in && det_armed_ff
         && (mode_ff == AESF_MODE_COMBINED);
   end

   assign flag_vec[1:0] = 2'b00;
   assign set_vec[1:0] = 2'b00;

   // empty and full only re-arm once their condition has dropped
   genvar gi;
   for (gi = 2; gi < 8; gi++) begin : g_flag
      aesf_flag_cell #(
         .REARM_ON_LOW (gi == AESF_EVT_EMPTY || gi == AESF_EVT_FULL)
      ) u_cell (
         .ref_clk_in (ref_clk_in),
         .rst_in     (rst_in),
         .enable_in  (int_enable_in[gi]),
         .cond_in    (cond_vec[gi]),
         .clear_in   (clear_evt),
         .flag_out   (flag_vec[gi]),
         .set_out    (set_vec[gi])
      );
   end

   // detector hold and capture halt
   logic nxt_det_armed;
   logic halt_ff;
   logic nxt_halt;

   always_comb begin
      nxt_det_armed = det_armed_ff;
      if (set_vec[AESF_EVT_COMBINED]) begin
         nxt_det_armed = 1'b0;
      end else if (mode_ff != AESF_MODE_COMBINED) begin
         nxt_det_armed = 1'b1;
      end else if (detector_rearm_on_clear_in && clear_evt && flag_vec[AESF_EVT_COMBINED]) begin
         nxt_det_armed = 1'b1;
      end
      nxt_halt = capture_halt_in
                 && (flag_vec[AESF_EVT_COMBINED] || set_vec[AESF_EVT_COMBINED])
                 && !(clear_evt && !set_vec[AESF_EVT_COMBINED]);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         det_armed_ff <= 1'b1;
         halt_ff <= 1'b0;
      end else begin
         det_armed_ff <= nxt_det_armed;
         halt_ff <= nxt_halt;
      end
   end

   // mode and fifo status bits
   logic [7:0] stat_ff;
   logic [7:0] nxt_stat;
   logic [7:0] nxt_flags_or;
   logic       new_ff;
   logic       nxt_new;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic       act_det_ff;
   logic       act_smp_ff;

   always_comb begin
      // flags one cycle ahead keep pending aligned with the flag register
      nxt_flags_or = set_vec | (flag_vec & {8{~clear_evt}});
      nxt_new = sample_written_in | (new_ff & ~rd_mode);
      nxt_stat = {|nxt_flags_or,
                  q_level,
                  q_full,
                  q_empty,
                  nxt_new,
                  nxt_mode};
      nxt_rdata = 8'h00;
      if (rd_mode) begin
         nxt_rdata = stat_ff;
      end else if (rd_flags) begin
         nxt_rdata = flag_vec;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stat_ff <= AESF_RST_MODE_STATUS;
         new_ff <= 1'b0;
         rdata_ff <= 8'h00;
         act_det_ff <= 1'b0;
         act_smp_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         new_ff <= nxt_new;
         rdata_ff <= nxt_rdata;
         act_det_ff <= (nxt_mode == AESF_MODE_WATCH) || (nxt_mode == AESF_MODE_COMBINED);
         act_smp_ff <= (nxt_mode == AESF_MODE_CONT) || (nxt_mode == AESF_MODE_COMBINED)
                       || (nxt_mode == AESF_MODE_BURST);
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign mode_out = mode_ff;
   assign detector_active_out = act_det_ff;
   assign sampling_active_out = act_smp_ff;
   assign detector_armed_out = det_armed_ff;
   assign capture_halt_out = halt_ff;
   assign any_flag_pending_out = stat_ff[AESF_BIT_PENDING];

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_cmd_taken;
      cmd_state_ff == AESF_MS_IDLE && mode_cmd_wr_in && cmd_legal;
   endsequence
   sequence s_last_beat;
      cmd_state_ff == AESF_MS_WAIT && !mode_cmd_wr_in && hb_tick && beats_ff == 2'h2;
   endsequence

   a_cmd_wait: assert property (s_cmd_taken |=> cmd_state_ff == AESF_MS_WAIT)
      else $error("mode command not taken");
   a_cmd_apply: assert property (s_last_beat |=> mode_ff == $past(cmd_ff))
      else $error("mode not applied on third beat");
   a_auto_wake: assert property (mode_ff == AESF_MODE_WATCH && activity_detect_in && !cmd_apply
      |=> mode_ff == AESF_MODE_CONT)
      else $error("watch mode did not move to continuous");
   a_burst_sleep: assert property (burst_done && !cmd_apply |=> mode_ff == AESF_MODE_SLEEP)
      else $error("triggered mode did not return to sleep");
   a_new_sample: assert property (sample_written_in |=> stat_ff[AESF_BIT_NEW_SAMPLE])
      else $error("new sample bit not set");
   a_empty_level: assert property (1'b1 |=> stat_ff[AESF_BIT_QUEUE_EMPTY]
      == ($past(queue_count_in) == 6'h00))
      else $error("empty level wrong");
   a_pend_sum: assert property (stat_ff[AESF_BIT_PENDING] == (|flag_vec))
      else $error("pending bit disagrees with flags");
   a_flag_enable: assert property ($rose(flag_vec[AESF_EVT_ACQ]) |-> $past(int_enable_in[AESF_EVT_ACQ]))
      else $error("acquisition flag set while disabled");
   a_clear_all: assert property (clear_evt |=> (flag_vec & ~$past(set_vec)) == 8'h00)
      else $error("clearing access left flags set");
   a_det_hold: assert property (!det_armed_ff && mode_ff == AESF_MODE_COMBINED
      && !(clear_evt && detector_rearm_on_clear_in) ##1 mode_ff == AESF_MODE_COMBINED
      |-> !det_armed_ff)
      else $error("detector re-armed without clear");
   a_halt_capture: assert property (capture_halt_in && set_vec[AESF_EVT_COMBINED] |=> halt_ff)
      else $error("capture did not halt");
endmodule
`default_nettype wire

/* dv/aesf_host_model.sv */
// host microcontroller model on the register access port
// assumes one core clock; requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module aesf_host_model (
   // clock
   input  wire logic       ref_clk_in,
   // register access port
   output logic            rd_stb_out,
   output logic            wr_stb_out,
   output logic      [7:0] addr_out
);
   initial begin
      rd_stb_out = 1'b0;
      wr_stb_out = 1'b0;
      addr_out   = 8'h00;
   end

   // one-cycle strobe; a read or a write of the flag register is how flags get cleared
   task automatic access(input bit wr, input logic [7:0] a, input int gap);
      repeat (gap) @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      rd_stb_out <= !wr;
      wr_stb_out <= wr;
      addr_out   <= a;
      @(posedge ref_clk_in);
      rd_stb_out <= 1'b0;
      wr_stb_out <= 1'b0;
      // released address is not left looking valid
      addr_out   <= ~a;
   endtask
endmodule
`default_nettype wire

/* dv/aesf_status_flags_tb.sv */
// self-checking bench for the status and event flag block
// assumes aesf_host_model drives the register port; short heartbeat for run time
`timescale 1ns/1ps
`default_nettype none
module aesf_status_flags_tb;
   import aesf_pkg::*;
   localparam int HB = 4;
   typedef struct {logic [7:0] e; logic [7:0] m;} aesf_note_t;
   logic       ref_clk_in = 1'b0;
   logic       rst_in     = 1'b1;
   logic       rd_stb;
   logic       wr_stb;
   logic [7:0] addr;
   logic [7:0] rdata;
   logic [7:0] int_en     = 8'h00;
   logic [7:0] burst_n    = 8'h02;
   logic       spi        = 1'b0;
   logic       cbw        = 1'b0;
   logic       rearm      = 1'b0;
   logic       halt       = 1'b0;
   logic       mode_wr    = 1'b0;
   logic       smp        = 1'b0;
   logic       act        = 1'b0;
   logic [4:0] thr        = 5'h05;
   logic [2:0] mode_cmd   = 3'h0;
   logic [5:0] cnt        = 6'h00;
   logic [2:0] mode;
   logic       det_act;
   logic       smp_act;
   logic       armed;
   logic       halt_o;
   logic       pend;
   logic       rd_pend    = 1'b0;
   int         err_count  = 0;
   int         n_checks   = 0;
   int         seed       = 32'h5C54;
   logic [2:0] codes [6]  = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0};
   aesf_note_t notes [$];

   always #4 ref_clk_in = ~ref_clk_in;

   aesf_status_flags #(.HB_CYCLES(HB)) dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .reg_rd_stb_in(rd_stb), .reg_wr_stb_in(wr_stb), .reg_addr_in(addr), .reg_rdata_out(rdata),
      .spi_mode_in(spi), .clear_by_write_in(cbw), .detector_rearm_on_clear_in(rearm),
      .capture_halt_in(halt), .int_enable_in(int_en), .level_threshold_in(thr), .burst_samples_in(burst_n),
      .mode_cmd_wr_in(mode_wr), .mode_cmd_in(mode_cmd),
      .sample_written_in(smp), .queue_count_in(cnt), .activity_detect_in(act),
      .mode_out(mode), .detector_active_out(det_act), .sampling_active_out(smp_act),
      .detector_armed_out(armed), .capture_halt_out(halt_o), .any_flag_pending_out(pend));

   aesf_host_model host (.ref_clk_in(ref_clk_in), .rd_stb_out(rd_stb), .wr_stb_out(wr_stb), .addr_out(addr));

   // read data lands one cycle after the strobe edge; oldest note is the matching one
   always @(posedge ref_clk_in) begin
      aesf_note_t n;
      if (rd_pend) begin
         n_checks++;
         if (notes.size() == 0) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=none", $time, rdata);
         end else begin
            n = notes.pop_front();
            if ((rdata & n.m) !== (n.e & n.m)) begin
               err_count++;
               $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata & n.m, n.e & n.m);
            end
         end
      end
      rd_pend <= rd_stb;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      notes.push_back('{e, m});
      host.access(1'b0, a, 0);
   endtask

   task automatic wr(input logic [7:0] a);
      host.access(1'b1, a, 2);
      cyc(2);
   endtask

   task automatic pulse(input bit which);
      @(posedge ref_clk_in);
      act <= which;
      smp <= !which;
      @(posedge ref_clk_in);
      act <= 1'b0;
      smp <= 1'b0;
      cyc(2);
   endtask

   task automatic cmd(input logic [2:0] c);
      @(posedge ref_clk_in);
      mode_wr  <= 1'b1;
      mode_cmd <= c;
      @(posedge ref_clk_in);
      mode_wr  <= 1'b0;
   endtask

   // heartbeat phase is free running, so allow the full three beats plus the apply cycle
   task automatic set_mode(input logic [2:0] c);
      int k;
      cmd(c);
      for (k = 0; k < 3 * HB + 2 && mode !== c; k++) @(posedge ref_clk_in);
      chk({5'h00, mode}, {5'h00, c});
   endtask

   task automatic conclude;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk_in);
      err_count++;
      conclude();
   end

   initial begin
      int k;
      logic [4:0] t;
      cyc(16);
      rst_in <= 1'b0;
      cyc(2);
      rd(AESF_OFS_MODE_STATUS, 8'h10, 8'hFF);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'hFF);
      rd(8'h0A, 8'h00, 8'hFF);
      // conditions present but every enable off
      cnt <= 6'h20;
      pulse(1'b0);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'hFF);
      rd(AESF_OFS_MODE_STATUS, 8'h68, 8'hF8);
      rd(AESF_OFS_MODE_STATUS, 8'h00, 8'h08);
      cnt <= 6'h00;
      foreach (codes[j]) begin
         set_mode(codes[j]);
         rd(AESF_OFS_MODE_STATUS, {5'h00, codes[j]}, 8'h07);
         if (codes[j] == AESF_MODE_CONT) chk({6'h00, det_act, smp_act}, 8'h01);
         if (codes[j] == AESF_MODE_COMBINED) chk({6'h00, det_act, smp_act}, 8'h03);
         if (codes[j] == AESF_MODE_WATCH) chk({6'h00, det_act, smp_act}, 8'h02);
         if (codes[j] == AESF_MODE_BURST) chk({6'h00, det_act, smp_act}, 8'h01);
         if (codes[j] == AESF_MODE_SLEEP || codes[j] == AESF_MODE_STANDBY) chk({6'h00, det_act, smp_act}, 8'h00);
      end
      cmd(AESF_MODE_RSV_A);
      cyc(3 * HB + 4);
      cmd(AESF_MODE_RSV_B);
      cyc(3 * HB + 4);
      chk({5'h00, mode}, 8'h00);
      int_en <= 8'hFC;
      set_mode(AESF_MODE_WATCH);
      pulse(1'b1);
      chk({5'h00, mode}, {5'h00, AESF_MODE_CONT});
      chk({7'h00, pend}, 8'h01);
      rd(AESF_OFS_MODE_STATUS, 8'h80, 8'h80);
      rd(AESF_OFS_EVENT_FLAGS, 8'h14, 8'hFF);
      pulse(1'b1);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'hFF);
      rd(AESF_OFS_MODE_STATUS, 8'h00, 8'h80);
      chk({7'h00, pend}, 8'h00);
      cnt <= 6'h03;
      cyc(2);
      cnt <= 6'h00;
      cyc(2);
      rd(AESF_OFS_EVENT_FLAGS, 8'h10, 8'hFF);
      pulse(1'b0);
      rd(AESF_OFS_EVENT_FLAGS, 8'h08, 8'h08);
      set_mode(AESF_MODE_STANDBY);
      pulse(1'b0);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h08);
      set_mode(AESF_MODE_BURST);
      pulse(1'b0);
      pulse(1'b0);
      for (k = 0; k < 4 && mode !== AESF_MODE_SLEEP; k++) @(posedge ref_clk_in);
      chk({5'h00, mode}, 8'h00);
      // endless burst count never falls back to sleep
      burst_n <= AESF_BURST_ENDLESS;
      set_mode(AESF_MODE_BURST);
      pulse(1'b0);
      pulse(1'b0);
      pulse(1'b0);
      chk({5'h00, mode}, {5'h00, AESF_MODE_BURST});
      rd(AESF_OFS_EVENT_FLAGS, 8'h08, 8'h08);
      cnt <= 6'h20;
      cyc(2);
      rd(AESF_OFS_MODE_STATUS, 8'h20, 8'h20);
      rd(AESF_OFS_EVENT_FLAGS, 8'h20, 8'h20);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h20);
      cnt <= 6'h1F;
      cyc(2);
      cnt <= 6'h20;
      cyc(2);
      rd(AESF_OFS_EVENT_FLAGS, 8'h20, 8'h20);
      // threshold never zero, so the below case exists
      for (k = 0; k < 4; k++) begin
         t = 5'($random(seed)) | 5'h01;
         thr <= t;
         cnt <= {1'b0, t} - 6'h01;
         cyc(3);
         rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h00);
         rd(AESF_OFS_MODE_STATUS, 8'h00, 8'h40);
         rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h40);
         cnt <= {1'b0, t};
         cyc(2);
         rd(AESF_OFS_MODE_STATUS, 8'h40, 8'h40);
         rd(AESF_OFS_EVENT_FLAGS, 8'h40, 8'h40);
      end
      spi   <= 1'b1;
      halt  <= 1'b1;
      rearm <= 1'b1;
      set_mode(AESF_MODE_COMBINED);
      wr(AESF_OFS_EVENT_FLAGS);
      pulse(1'b1);
      chk({6'h00, armed, halt_o}, 8'h01);
      rd(AESF_OFS_EVENT_FLAGS, 8'h80, 8'h80);
      rd(AESF_OFS_EVENT_FLAGS, 8'h80, 8'h80);
      wr(AESF_OFS_EVENT_FLAGS);
      chk({6'h00, armed, halt_o}, 8'h02);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h80);
      halt  <= 1'b0;
      rearm <= 1'b0;
      pulse(1'b1);
      chk({6'h00, armed, halt_o}, 8'h00);
      wr(AESF_OFS_EVENT_FLAGS);
      chk({7'h00, armed}, 8'h00);
      pulse(1'b1);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h80);
      set_mode(AESF_MODE_CONT);
      cyc(2);
      chk({7'h00, armed}, 8'h01);
      spi <= 1'b0;
      cbw <= 1'b1;
      pulse(1'b0);
      rd(AESF_OFS_EVENT_FLAGS, 8'h08, 8'h08);
      rd(AESF_OFS_EVENT_FLAGS, 8'h08, 8'h08);
      wr(AESF_OFS_EVENT_FLAGS);
      rd(AESF_OFS_EVENT_FLAGS, 8'h00, 8'h08);
      cyc(4);
      if (notes.size() != 0) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, notes.size(), 0);
      end
      conclude();
   end
endmodule
`default_nettype wire
